// ===== logic/can_mode_consts.vh
// Offsets, field positions, reset values and counts of the mode-control block
`ifndef CAN_MODE_CONSTS_VH
`define CAN_MODE_CONSTS_VH
`define MODE_CTRL_OFS        4'h0
`define STATUS_OFS           4'h1
`define ERROR_COUNT_OFS      4'h2
`define WINDOW_START_OFS     4'h3
`define FIFO_PTR_OFS         4'h4
`define EVENT_OFS            4'h5
`define EVENT_ENABLE_OFS     4'h6
`define LINK_EVENT_OFS       4'h7
`define BIT_RESET            0
`define BIT_LISTEN           1
`define BIT_SELF_TEST        2
`define BIT_FILTER           3
`define BIT_SLEEP            4
`define EV_WAKE              0
`define EV_WARN              1
`define EV_RECEIVE           2
`define MODE_RESET_VAL       8'h01
`define TX_RECOVER_LOAD      8'h7F
`define BUS_FREE_BITS        4'hB
`define RECOVER_SEQS         8'h80
`define DIVIDED_CLOCK_OUTPUT_HOLD_BITS     5'h0F
`define PTR_ZERO             8'h00
`endif

// ===== logic/bus_free_detect.v
// Counter of consecutive recessive bits giving a bus-free pulse
`timescale 1ns/1ns
module bus_free_detect (
   input  wire       clk,
   input  wire       srst,
   input  wire       bit_tick,
   input  wire       rx_bit,
   output reg        bus_free
);
`include "can_mode_consts.vh"
   reg [3:0] run_q;

   always @(posedge clk) begin
      if (srst) begin
         run_q    <= 4'h0;
         bus_free <= 1'b0;
      end else begin
         bus_free <= 1'b0;
         if (bit_tick) begin
            if (!rx_bit) begin
               run_q <= 4'h0;
            end else if (run_q == `BUS_FREE_BITS - 4'h1) begin
               run_q    <= 4'h0;
               bus_free <= 1'b1;
            end else begin
               run_q <= run_q + 4'h1;
            end
         end
      end
   end
endmodule // bus_free_detect

// ===== logic/half_rate_sync.v
// Half-rate internal clock phase and synchroniser of the reset request
`timescale 1ns/1ns
module half_rate_sync (
   input  wire       clk,
   input  wire       srst,
   input  wire       req_in,
   output reg        phase,
   output reg        req_sync
);
   always @(posedge clk) begin
      if (srst) begin
         phase    <= 1'b0;
         req_sync <= 1'b1;
      end else begin
         phase <= ~phase;
         if (phase) begin
            req_sync <= req_in;
         end
      end
   end
endmodule // half_rate_sync

// ===== logic/can_mode_and_reset_control.v
// Mode register, reset/bus-off, sleep and wake-up control of a CAN node
`timescale 1ns/1ns
module can_mode_and_reset_control (
   input  wire        clk,
   input  wire        srst,
   input  wire        ext_reset,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        rx_pin,
   input  wire        bit_tick,
   input  wire        bus_off_event,
   input  wire        tx_done,
   input  wire        tx_self_request,
   input  wire        ack_seen,
   input  wire        rx_frame_ok,
   input  wire        rx_error_inc,
   input  wire        tx_error_inc,
   input  wire        fifo_write,
   input  wire        fifo_release,
   input  wire        int_pin_low,
   output reg         bus_on,
   output reg         abort_traffic,
   output reg         filter_single,
   output reg         drive_ack,
   output reg         tx_allowed,
   output reg         error_passive_force,
   output reg         tx_success,
   output reg         store_frame,
   output reg         receive_enable,
   output reg         sleeping,
   output reg         oscillator_on,
   output reg         divided_clock_output,
   output reg         interrupt_n,
   output reg  [7:0]  fifo_read_ptr,
   output reg  [7:0]  fifo_write_ptr
);
`include "can_mode_consts.vh"
   localparam ST_RESET   = 4'b0001;
   localparam ST_WAIT    = 4'b0010;
   localparam ST_ON      = 4'b0100;
   localparam ST_SLEEP   = 4'b1000;

   // Pin synchronisers
   reg        rx_s1_q, rx_s2_q, ext_s1_q, ext_s2_q, int_s1_q, int_s2_q;
   reg        tick_q;
   reg [3:0]  state_q;
   reg        req_q;
   reg        listen_q, self_test_q, filter_q, sleep_q;
   reg        boff_cause_q;
   reg [7:0]  seq_left_q;
   reg [7:0]  rx_err_q, tx_err_q;
   reg [7:0]  window_start_q;
   reg [2:0]  events_q;
   reg [2:0]  enable_q;
   reg        sleep_arm_q;
   reg        rx_block_q;
   reg [4:0]  hold_bits_q;
   reg        rx_prev_q;
   reg        pending_q;
   wire       phase;
   wire       req_sync;
   wire       bus_free;
   // Count restarts in reset mode so the bus-on wait starts fresh
   wire       free_clr = srst | (state_q == ST_RESET);
   wire       wr = avs_write & ~avs_waitrequest;
   wire       in_reset = req_sync;
   wire       activity = rx_prev_q & ~rx_s2_q;
   wire       any_event = |(events_q & enable_q);
   wire [7:0] mode_view = {3'b000, sleep_q, filter_q, self_test_q,
                           listen_q, req_sync};

   half_rate_sync u_sync (
      .clk      (clk),
      .srst     (srst),
      .req_in   (req_q),
      .phase    (phase),
      .req_sync (req_sync)
   );

   bus_free_detect u_free (
      .clk      (clk),
      .srst     (free_clr),
      .bit_tick (tick_q),
      .rx_bit   (rx_s2_q),
      .bus_free (bus_free)
   );

   always @(posedge clk) begin
      if (srst) begin
         rx_s1_q  <= 1'b1;
         rx_s2_q  <= 1'b1;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         int_s1_q <= 1'b0;
         int_s2_q <= 1'b0;
         rx_prev_q <= 1'b1;
         tick_q   <= 1'b0;
      end else begin
         rx_s1_q  <= rx_pin;
         rx_s2_q  <= rx_s1_q;
         ext_s1_q <= ext_reset;
         ext_s2_q <= ext_s1_q;
         int_s1_q <= int_pin_low;
         int_s2_q <= int_s1_q;
         rx_prev_q <= rx_s2_q;
         tick_q   <= bit_tick;
      end
   end

   // Register bus: one wait cycle so every access answers in two edges
   always @(posedge clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read & avs_waitrequest) begin
            case (avs_address)
               `MODE_CTRL_OFS:
                  avs_readdata <= {24'h00_0000, mode_view};
               `STATUS_OFS:
                  avs_readdata <= {24'h00_0000, state_q, boff_cause_q,
                                   rx_block_q, sleep_arm_q, ext_s2_q};
               `ERROR_COUNT_OFS:
                  avs_readdata <= {16'h0000, tx_err_q, rx_err_q};
               `WINDOW_START_OFS:
                  avs_readdata <= {24'h00_0000, window_start_q};
               `FIFO_PTR_OFS:
                  avs_readdata <= {16'h0000, fifo_write_ptr, fifo_read_ptr};
               `EVENT_OFS:
                  avs_readdata <= {29'h0000_0000, events_q};
               `EVENT_ENABLE_OFS:
                  avs_readdata <= {29'h0000_0000, enable_q};
               default:
                  avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Mode register and event bits
   always @(posedge clk) begin
      if (srst) begin
         req_q          <= 1'b1;
         listen_q       <= 1'b0;
         self_test_q    <= 1'b0;
         filter_q       <= 1'b0;
         sleep_q        <= 1'b0;
         window_start_q <= `PTR_ZERO;
         enable_q       <= 3'b000;
         events_q       <= 3'b000;
      end else begin
         if (wr && avs_address == `MODE_CTRL_OFS) begin
            req_q <= avs_writedata[`BIT_RESET] | ext_s2_q;
            if (in_reset) begin
               listen_q    <= avs_writedata[`BIT_LISTEN];
               self_test_q <= avs_writedata[`BIT_SELF_TEST];
               filter_q    <= avs_writedata[`BIT_FILTER];
            end
            if (!avs_writedata[`BIT_SLEEP])
               sleep_q <= 1'b0;
            else if (!in_reset && sleep_arm_q)
               sleep_q <= 1'b1;
         end
         if (ext_s2_q || bus_off_event)
            req_q <= 1'b1;
         if (state_q == ST_SLEEP && (activity || int_s2_q))
            sleep_q <= 1'b0;
         if (wr && avs_address == `WINDOW_START_OFS && in_reset)
            window_start_q <= avs_writedata[7:0];
         if (wr && avs_address == `EVENT_ENABLE_OFS)
            enable_q <= avs_writedata[2:0];
         // Set wins over a same-cycle write-one-to-clear
         if (wr && avs_address == `EVENT_OFS)
            events_q <= events_q & ~avs_writedata[2:0];
         if (bus_off_event && enable_q[`EV_WARN])
            events_q[`EV_WARN] <= 1'b1;
         if (tx_done && tx_self_request && enable_q[`EV_RECEIVE])
            events_q[`EV_RECEIVE] <= 1'b1;
         if (enable_q[`EV_WAKE] &&
             ((wr && avs_address == `MODE_CTRL_OFS &&
               avs_writedata[`BIT_SLEEP] && !in_reset && sleep_arm_q &&
               (pending_q || activity)) ||
              (state_q == ST_SLEEP && !sleep_q)))
            events_q[`EV_WAKE] <= 1'b1;
      end
   end

   // Operating state, bus-on wait, sleep
   always @(posedge clk) begin
      if (srst) begin
         state_q      <= ST_RESET;
         boff_cause_q <= 1'b0;
         seq_left_q   <= 8'h01;
         sleep_arm_q  <= 1'b0;
         rx_block_q   <= 1'b0;
         hold_bits_q  <= 5'h00;
      end else begin
         if (bus_off_event)
            boff_cause_q <= 1'b1;
         case (state_q)
            ST_RESET: begin
               sleep_arm_q <= 1'b0;
               if (!in_reset) begin
                  state_q    <= ST_WAIT;
                  seq_left_q <= boff_cause_q ? `RECOVER_SEQS
                                             : 8'h01;
               end
            end
            ST_WAIT: begin
               if (in_reset)
                  state_q <= ST_RESET;
               else if (bus_free) begin
                  sleep_arm_q <= 1'b1;
                  if (seq_left_q == 8'h01) begin
                     state_q      <= ST_ON;
                     boff_cause_q <= 1'b0;
                  end else
                     seq_left_q <= seq_left_q - 8'h01;
               end
            end
            ST_ON: begin
               if (bus_free) begin
                  sleep_arm_q <= 1'b1;
                  rx_block_q  <= 1'b0;
               end
               if (in_reset)
                  state_q <= ST_RESET;
               else if (sleep_q && !pending_q && !activity) begin
                  state_q     <= ST_SLEEP;
                  hold_bits_q <= `DIVIDED_CLOCK_OUTPUT_HOLD_BITS;
               end
            end
            ST_SLEEP: begin
               if (tick_q && hold_bits_q != 5'h00)
                  hold_bits_q <= hold_bits_q - 5'h01;
               if (in_reset)
                  state_q <= ST_RESET;
               else if (!sleep_q) begin
                  state_q    <= ST_ON;
                  rx_block_q <= 1'b1;
               end
            end
            default: state_q <= ST_RESET;
         endcase
      end
   end

   // Error counters
   always @(posedge clk) begin
      if (srst) begin
         rx_err_q <= 8'h00;
         tx_err_q <= 8'h00;
      end else if (bus_off_event) begin
         rx_err_q <= 8'h00;
         tx_err_q <= `TX_RECOVER_LOAD;
      end else if (state_q == ST_WAIT && boff_cause_q) begin
         if (bus_free && tx_err_q != 8'h00)
            tx_err_q <= tx_err_q - 8'h01;
      end else if (!listen_q) begin
         if (rx_error_inc && rx_err_q != 8'hFF)
            rx_err_q <= rx_err_q + 8'h01;
         if (tx_error_inc && tx_err_q != 8'hFF)
            tx_err_q <= tx_err_q + 8'h01;
      end
   end

   // Fifo pointers
   always @(posedge clk) begin
      if (srst) begin
         fifo_read_ptr  <= `PTR_ZERO;
         fifo_write_ptr <= `PTR_ZERO;
      end else if (req_q || bus_off_event) begin
         fifo_read_ptr  <= window_start_q;
         fifo_write_ptr <= window_start_q;
      end else begin
         if (fifo_write)
            fifo_write_ptr <= fifo_write_ptr + 8'h01;
         if (fifo_release)
            fifo_read_ptr <= fifo_read_ptr + 8'h01;
      end
   end

   // Registered outputs
   always @(posedge clk) begin
      if (srst) begin
         pending_q            <= 1'b0;
         bus_on               <= 1'b0;
         abort_traffic        <= 1'b1;
         filter_single        <= 1'b0;
         drive_ack            <= 1'b0;
         tx_allowed           <= 1'b0;
         error_passive_force  <= 1'b0;
         tx_success           <= 1'b0;
         store_frame          <= 1'b0;
         receive_enable       <= 1'b0;
         sleeping             <= 1'b0;
         oscillator_on        <= 1'b1;
         divided_clock_output <= 1'b0;
         interrupt_n          <= 1'b1;
      end else begin
         pending_q      <= any_event;
         bus_on         <= (state_q == ST_ON) & ~in_reset;
         abort_traffic  <= in_reset;
         filter_single  <= filter_q;
         drive_ack      <= rx_frame_ok & ~listen_q
                           & (state_q == ST_ON);
         tx_allowed     <= (state_q == ST_ON) & ~listen_q;
         error_passive_force <= listen_q;
         tx_success     <= tx_done & (ack_seen | self_test_q);
         store_frame    <= tx_done & ~listen_q;
         receive_enable <= (state_q == ST_ON) & ~rx_block_q;
         sleeping       <= (state_q == ST_SLEEP);
         // Oscillator stops only once the clock hold-off has run out
         oscillator_on  <= !(state_q == ST_SLEEP && hold_bits_q == 5'h00);
         divided_clock_output <= (state_q == ST_SLEEP &&
                                  hold_bits_q == 5'h00) ? 1'b0
                                 : phase;
         interrupt_n    <= ~any_event;
      end
   end
endmodule // can_mode_and_reset_control

// ===== testbench/can_mode_sva.sv
// Port-level checker of the mode and reset control block
`timescale 1ns/1ns
module can_mode_sva (
   input logic        clk,
   input logic        srst,
   input logic        ext_reset,
   input logic [3:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic        bit_tick,
   input logic        bus_off_event,
   input logic        tx_done,
   input logic        bus_on,
   input logic        abort_traffic,
   input logic        drive_ack,
   input logic        tx_allowed,
   input logic        error_passive_force,
   input logic        store_frame,
   input logic        sleeping,
   input logic        divided_clock_output,
   input logic [7:0]  fifo_read_ptr,
   input logic [7:0]  fifo_write_ptr
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [4:0] hold_q;
   // Bit times spent asleep, saturating so it never wraps
   always @(posedge clk) begin
      if (srst || !sleeping)
         hold_q <= 5'h00;
      else if (bit_tick && hold_q != 5'h1F)
         hold_q <= hold_q + 5'h01;
   end
   sequence s_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   chk_answer_next: assert property (s_taken |=> s_answer)
      else $error("bus answer not one cycle after request");
   chk_mode_reserved: assert property (
      !avs_waitrequest && avs_read && avs_address == 4'h0
      |-> avs_readdata[31:5] == '0) else $error("mode upper bits set");
   chk_listen_quiet: assert property (
      error_passive_force |-> !drive_ack && !tx_allowed)
      else $error("listen only node drives bus");
   chk_reset_offbus: assert property (abort_traffic |-> !bus_on)
      else $error("bus on while in reset mode");
   chk_ext_forces: assert property (
      ext_reset [*8] |-> abort_traffic)
      else $error("external reset did not force reset mode");
   chk_busoff_enter: assert property (
      bus_off_event |-> ##[1:8] abort_traffic)
      else $error("bus-off did not enter reset mode");
   chk_frame_stored: assert property (
      tx_done |-> ##[1:3] store_frame)
      else $error("sent frame not stored");
   chk_ptrs_equal: assert property (
      $rose(abort_traffic) |-> ##[0:2] fifo_read_ptr == fifo_write_ptr)
      else $error("pointers differ after reset entry");
   chk_sleep_clock: assert property (
      sleeping && hold_q < 5'h0E |=> $changed(divided_clock_output))
      else $error("clock output stopped too early");
endmodule // can_mode_sva
bind can_mode_and_reset_control can_mode_sva i_can_mode_sva (.*);

// ===== testbench/can_bus_model.sv
// Bus-side model: bit timing ticks and the received bus level
`timescale 1ns/1ns
module can_bus_model (
   input  logic clk,
   input  logic srst,
   input  logic hold_dom,
   output logic rx_pin,
   output logic bit_tick
);
   logic [1:0] div_q;
   // Released bus goes to its recessive pull level
   assign rx_pin = !hold_dom;
   always @(posedge clk) begin
      if (srst)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1;
      bit_tick <= (div_q == 2'h3);
   end
endmodule // can_bus_model

// ===== testbench/can_mode_and_reset_control_tb_top.sv
// Testbench of the mode and reset control block
`timescale 1ns/1ns
module can_mode_and_reset_control_tb_top;
   logic        clk, srst, ext_reset, avs_read, avs_write, hold_dom;
   logic        avs_waitrequest, rx_pin, bit_tick, bus_on, abort_traffic;
   logic        filter_single, drive_ack, tx_allowed, error_passive_force;
   logic        tx_success, store_frame, receive_enable, sleeping;
   logic        oscillator_on, divided_clock_output, interrupt_n, txs;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdat;
   logic [7:0]  fifo_read_ptr, fifo_write_ptr;
   logic [9:0]  ev;
   int          fails, comparisons, t;
   can_mode_and_reset_control i_can_mode_and_reset_control (
      .bus_off_event(ev[9]), .tx_done(ev[8]), .tx_self_request(ev[7]),
      .ack_seen(ev[6]), .rx_frame_ok(ev[5]), .rx_error_inc(ev[4]),
      .tx_error_inc(ev[3]), .fifo_write(ev[2]), .fifo_release(ev[1]),
      .int_pin_low(ev[0]), .*);
   can_bus_model i_can_bus_model (.*);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task close_out;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
      end
   endtask
   task tmo;
      fails++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      close_out;
   endtask
   // One access; waits for the answer, then releases the request
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20)
         tmo;
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask
   // One cycle of events; tx_success is caught while it stands
   task pulse(input logic [9:0] m);
      ev <= m;
      @(posedge clk);
      ev <= 10'h000;
      @(negedge clk);
      txs = tx_success;
      @(posedge clk);
   endtask
   // Waits for bus_on, sleeping, abort_traffic or receive_enable
   task wt(input int s, input logic v);
      int n;
      logic x;
      t = 0;
      for (n = 0; n < 7000; n++) begin
         x = (s == 0) ? bus_on : (s == 1) ? sleeping
           : (s == 2) ? abort_traffic : receive_enable;
         if (x === v)
            break;
         @(posedge clk);
         if (bit_tick === 1'b1)
            t++;
      end
      if (n == 7000)
         tmo;
   endtask
   initial begin
      srst = 1'b1;
      ext_reset = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      ev = 10'h000;
      hold_dom = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({16'h0000, fifo_write_ptr, fifo_read_ptr},
          32'h0000_0000);
      rd(4'h0, 32'h0000_0001);
      wr(4'h0, 32'h0000_00FF);
      rd(4'h0, 32'h0000_000F);
      wr(4'h0, 32'h0000_000E);
      wt(2, 1'b0);
      pulse(10'h018);
      rd(4'h2, 32'h0000_0000);
      chk({30'h0, filter_single, error_passive_force},
          32'h0000_0003);
      wr(4'h0, 32'h0000_0001);
      wt(2, 1'b1);
      // Option bits keep their values: the write came outside reset
      rd(4'h0, 32'h0000_000F);
      wr(4'h3, 32'h0000_0020);
      // Dominant level held while reset clears restarts bus-free count
      hold_dom <= 1'b1;
      wr(4'h0, 32'h0000_0000);
      wt(2, 1'b0);
      repeat (30) @(posedge clk);
      hold_dom <= 1'b0;
      wt(0, 1'b1);
      chk({31'h0, t >= 11}, 32'h0000_0001);
      wr(4'h0, 32'h0000_0008);
      rd(4'h0, 32'h0000_0000);
      pulse(10'h100);
      chk({31'h0, txs}, 32'h0000_0000);
      pulse(10'h140);
      chk({31'h0, txs}, 32'h0000_0001);
      wr(4'h6, 32'h0000_0007);
      wr(4'h0, 32'h0000_0010);
      wt(1, 1'b1);
      repeat (100) @(posedge clk);
      chk({30'h0, oscillator_on, divided_clock_output},
          32'h0000_0000);
      wr(4'h0, 32'h0000_0000);
      wt(1, 1'b0);
      rd(4'h5, 32'h0000_0001);
      wr(4'h5, 32'h0000_0001);
      wt(3, 1'b1);
      // Second sleep, ended by a dominant edge on the bus
      wr(4'h0, 32'h0000_0010);
      wt(1, 1'b1);
      hold_dom <= 1'b1;
      wt(1, 1'b0);
      chk({30'h0, oscillator_on, receive_enable},
          32'h0000_0002);
      rd(4'h5, 32'h0000_0001);
      // Sleep asked for while the wake event is still pending
      wr(4'h0, 32'h0000_0010);
      repeat (20) @(posedge clk);
      chk({31'h0, sleeping}, 32'h0000_0000);
      wr(4'h0, 32'h0000_0000);
      wr(4'h5, 32'h0000_0001);
      hold_dom <= 1'b0;
      wt(3, 1'b1);
      chk({31'h0, t >= 11}, 32'h0000_0001);
      wr(4'h0, 32'h0000_0001);
      wt(2, 1'b1);
      chk({24'h0, fifo_read_ptr}, 32'h0000_0020);
      wr(4'h0, 32'h0000_0005);
      pulse(10'h100);
      chk({31'h0, txs}, 32'h0000_0001);
      wr(4'h0, 32'h0000_0001);
      wr(4'h0, 32'h0000_0000);
      wt(0, 1'b1);
      pulse(10'h006);
      pulse(10'h200);
      wt(2, 1'b1);
      chk({16'h0000, fifo_write_ptr, fifo_read_ptr},
          32'h0000_2020);
      rd(4'h2, 32'h0000_7F00);
      pulse(10'h100);
      rd(4'h5, 32'h0000_0002);
      chk({31'h0, interrupt_n}, 32'h0000_0000);
      pulse(10'h180);
      rd(4'h5, 32'h0000_0006);
      wr(4'h5, 32'h0000_0006);
      wr(4'h0, 32'h0000_0000);
      wt(0, 1'b1);
      chk({31'h0, t >= 1408}, 32'h0000_0001);
      ext_reset <= 1'b1;
      wt(2, 1'b1);
      wr(4'h0, 32'h0000_0000);
      repeat (4) @(posedge clk);
      rd(4'h0, 32'h0000_0001);
      ext_reset <= 1'b0;
      rd(4'h9, 32'h0000_0000);
      close_out;
   end
endmodule // can_mode_and_reset_control_tb_top
